// File: rtl/port_direction_control.sv
// Port direction registers with shared-interrupt pin side effect
`timescale 1ns/10ps
module port_direction_control
	import port_dir_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic bus_bit_op,
	input wire logic [2:0] bus_bit_sel,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] port2_latch,
	input wire logic [7:0] port3_latch,
	input wire logic [7:0] port4_latch,
	input wire logic [7:0] port12_latch,
	output logic [7:0] port2_out,
	output logic [7:0] port2_oe,
	output logic [7:0] port3_out,
	output logic [7:0] port3_oe,
	output logic [7:0] port4_out,
	output logic [7:0] port4_oe,
	output logic [7:0] port12_out,
	output logic [7:0] port12_oe,
	output logic [NUM_SHARED_PINS-1:0] intr_request_set
);
	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic [NUM_DIR_REGS-1:0] decode_reg(input logic [15:0] addr);
		decode_reg = {addr == PORT12_DIRECTION_ADDR, addr == PORT4_DIRECTION_ADDR,
			addr == PORT3_DIRECTION_ADDR, addr == PORT2_DIRECTION_ADDR};
	endfunction : decode_reg

	logic [7:0] dir_reg [NUM_DIR_REGS];
	logic [7:0] dir_next [NUM_DIR_REGS];
	logic [7:0] latch_in [NUM_DIR_REGS];
	logic [7:0] out_reg [NUM_DIR_REGS];
	logic [7:0] out_next [NUM_DIR_REGS];
	logic [7:0] oe_reg [NUM_DIR_REGS];
	logic [7:0] oe_next [NUM_DIR_REGS];
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [NUM_DIR_REGS-1:0] hit;
	access_kind_t kind;
	logic [NUM_DIR_REGS-1:0] wr_hit;
	logic [7:0] wr_mask;
	logic [NUM_SHARED_PINS-1:0] tap_en;
	logic [NUM_SHARED_PINS-1:0] tap_level;

	assign latch_in[0] = port2_latch;
	assign latch_in[1] = port3_latch;
	assign latch_in[2] = port4_latch;
	assign latch_in[3] = port12_latch;

	always_comb begin
		hit = decode_reg(bus_addr);
		if (!bus_wr) begin
			kind = ACC_NONE;
		end else if (bus_bit_op) begin
			kind = ACC_BIT;
		end else begin
			kind = ACC_BYTE;
		end
	end

	// ****************************************
	// Write strobes
	// ****************************************
	// Bit writes get a one-hot mask (byte writes use 8'hff), so a bit write cannot spill into its neighbours
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h00;
		bit_mask[sel] = 1'b1;
	endfunction : bit_mask

	always_comb begin
		wr_hit = '0;
		wr_mask = 8'h00;
		case (kind)
			ACC_BYTE: begin
				wr_hit = hit;
				wr_mask = 8'hff;
			end
			ACC_BIT: begin
				wr_hit = hit;
				wr_mask = bit_mask(bus_bit_sel);
			end
			ACC_NONE: begin
				wr_hit = '0;
				wr_mask = 8'h00;
			end
			default: begin
				wr_hit = '0;
				wr_mask = 8'h00;
			end
		endcase
	end

	// ****************************************
	// Direction registers
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NUM_DIR_REGS; g++) begin : g_dir
			always_comb begin
				dir_next[g] = dir_reg[g];
				if (wr_hit[g]) begin
					dir_next[g] = (dir_reg[g] & ~wr_mask) | (bus_wdata & wr_mask);
				end
			end

			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					dir_reg[g] <= DIRECTION_RESET;
				end else begin
					dir_reg[g] <= dir_next[g];
				end
			end
		end
	endgenerate

	// ****************************************
	// Pin drivers
	// ****************************************
	generate
		for (g = 0; g < NUM_DIR_REGS; g++) begin : g_pin
			always_comb begin
				// Taken from the new direction so pins follow a write at the same edge
				oe_next[g] = ~dir_next[g];
				out_next[g] = latch_in[g] & ~dir_next[g];
			end

			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					oe_reg[g] <= ~DIRECTION_RESET;
					out_reg[g] <= 8'h00;
				end else begin
					oe_reg[g] <= oe_next[g];
					out_reg[g] <= out_next[g];
				end
			end
		end
	endgenerate

	// ****************************************
	// Read path
	// ****************************************
	// Zero unless a read hits, so an idle bus never shows stale data
	always_comb begin
		rdata_next = 8'h00;
		for (int i = 0; i < NUM_DIR_REGS; i++) begin
			if (bus_rd && hit[i]) begin
				rdata_next = dir_reg[i];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// Shared interrupt pins
	// ****************************************
	// Only driven levels count; input-mode pins are watched by the interrupt block itself
	always_comb begin
		tap_en[0] = oe_reg[1][PORT3_PIN0_BIT];
		tap_level[0] = out_reg[1][PORT3_PIN0_BIT];
		tap_en[1] = oe_reg[1][PORT3_PIN1_BIT];
		tap_level[1] = out_reg[1][PORT3_PIN1_BIT];
		tap_en[2] = oe_reg[2][PORT4_PIN3_BIT];
		tap_level[2] = out_reg[2][PORT4_PIN3_BIT];
	end

	pin_edge_flag u_port3_pin0 (
		.core_clk(core_clk),
		.rstn(rstn),
		.drive_en(tap_en[0]),
		.drive_level(tap_level[0]),
		.change_pulse(intr_request_set[0])
	);
	pin_edge_flag u_port3_pin1 (
		.core_clk(core_clk),
		.rstn(rstn),
		.drive_en(tap_en[1]),
		.drive_level(tap_level[1]),
		.change_pulse(intr_request_set[1])
	);
	pin_edge_flag u_port4_pin3 (
		.core_clk(core_clk),
		.rstn(rstn),
		.drive_en(tap_en[2]),
		.drive_level(tap_level[2]),
		.change_pulse(intr_request_set[2])
	);

	// ****************************************
	// Outputs
	// ****************************************
	// Every output comes straight from its register
	assign bus_rdata = rdata_reg;
	assign port2_out = out_reg[0];
	assign port2_oe = oe_reg[0];
	assign port3_out = out_reg[1];
	assign port3_oe = oe_reg[1];
	assign port4_out = out_reg[2];
	assign port4_oe = oe_reg[2];
	assign port12_out = out_reg[3];
	assign port12_oe = oe_reg[3];
endmodule : port_direction_control

// File: rtl/port_dir_pkg.sv
// Constants for the port direction control block
package port_dir_pkg;
	localparam logic [15:0] PORT2_DIRECTION_ADDR = 16'hff22;
	localparam logic [15:0] PORT3_DIRECTION_ADDR = 16'hff23;
	localparam logic [15:0] PORT4_DIRECTION_ADDR = 16'hff24;
	localparam logic [15:0] PORT12_DIRECTION_ADDR = 16'hff2c;
	localparam logic [7:0] DIRECTION_RESET = 8'hff;
	localparam int NUM_DIR_REGS = 4;
	localparam int PORT3_PIN0_BIT = 0;
	localparam int PORT3_PIN1_BIT = 1;
	localparam int PORT4_PIN3_BIT = 3;
	localparam int NUM_SHARED_PINS = 3;
	typedef enum logic [1:0] {
		ACC_NONE = 2'b00,
		ACC_BYTE = 2'b01,
		ACC_BIT = 2'b10
	} access_kind_t;
endpackage : port_dir_pkg

// File: rtl/pin_edge_flag.sv
// Level-change detector for one shared interrupt pin
`timescale 1ns/10ps
module pin_edge_flag
	import port_dir_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic drive_en,
	input wire logic drive_level,
	output logic change_pulse
);
	logic last_reg;
	logic last_next;
	logic pulse_reg;
	logic pulse_next;

	always_comb begin
		last_next = drive_level;
		pulse_next = drive_en && (drive_level != last_reg);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			last_reg <= 1'b0;
			pulse_reg <= 1'b0;
		end else begin
			last_reg <= last_next;
			pulse_reg <= pulse_next;
		end
	end

	assign change_pulse = pulse_reg;
endmodule : pin_edge_flag

// File: tb/port_dir_props.sv
// Port-level assertions for the direction control block
`timescale 1ns/10ps
module port_dir_props
	import port_dir_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic bus_bit_op,
	input wire logic [2:0] bus_bit_sel,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic [7:0] port2_latch,
	input wire logic [7:0] port2_out,
	input wire logic [7:0] port2_oe,
	input wire logic [7:0] port3_out,
	input wire logic [7:0] port3_oe,
	input wire logic [7:0] port4_oe,
	input wire logic [2:0] intr_request_set
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_byte_write_dir: assert property (bus_wr && !bus_bit_op && bus_addr == PORT2_DIRECTION_ADDR
		|=> port2_oe == ~$past(bus_wdata)) else $error("byte write not seen on enables");
	a_bit_write_keeps: assert property (bus_wr && bus_bit_op && bus_addr == PORT4_DIRECTION_ADDR
		|=> ((port4_oe ^ $past(port4_oe)) & ~(8'h01 << $past(bus_bit_sel))) == 8'h00)
		else $error("bit write touched other bits");
	a_read_back_dir: assert property (bus_rd && !bus_wr && bus_addr == PORT2_DIRECTION_ADDR
		|=> bus_rdata == ~$past(port2_oe)) else $error("read data differs from direction");
	a_out_from_latch: assert property (port2_out == ($past(port2_latch) & port2_oe))
		else $error("pin output not latch gated by enable");
	a_flag_on_change: assert property (port3_oe[0] && $past(port3_oe[0]) && $changed(port3_out[0])
		|=> intr_request_set[0]) else $error("missing request pulse");
	a_no_input_flag: assert property (!port4_oe[3] ##1 !port4_oe[3] |=> !intr_request_set[2])
		else $error("request pulse while input");
endmodule : port_dir_props
bind port_direction_control port_dir_props u_props (.core_clk, .rstn, .bus_addr, .bus_wr, .bus_rd, .bus_bit_op,
	.bus_bit_sel, .bus_wdata, .bus_rdata, .port2_latch, .port2_out, .port2_oe, .port3_out, .port3_oe, .port4_oe,
	.intr_request_set);

// File: tb/port_direction_control_test.sv
// Self-checking bench for the direction control block
`timescale 1ns/10ps
module port_direction_control_test import port_dir_pkg::*; ;
	logic core_clk, rstn, bus_wr, bus_rd, bus_bit_op, b;
	logic [15:0] bus_addr;
	logic [2:0] bus_bit_sel, s, intr_request_set;
	logic [7:0] bus_wdata, bus_rdata, port2_latch, port3_latch, port4_latch, port12_latch, d;
	logic [7:0] port2_out, port2_oe, port3_out, port3_oe, port4_out, port4_oe, port12_out, port12_oe, dm [4];
	logic [15:0] ad [4] = '{PORT2_DIRECTION_ADDR, PORT3_DIRECTION_ADDR, PORT4_DIRECTION_ADDR, PORT12_DIRECTION_ADDR};
	int miscompares = 0;
	int checked = 0;
	int i;
	port_direction_control uut (.core_clk, .rstn, .bus_addr, .bus_wr, .bus_rd, .bus_bit_op, .bus_bit_sel,
		.bus_wdata, .bus_rdata, .port2_latch, .port3_latch, .port4_latch, .port12_latch, .port2_out, .port2_oe,
		.port3_out, .port3_oe, .port4_out, .port4_oe, .port12_out, .port12_oe, .intr_request_set);
	function logic [7:0] upd(logic [7:0] o, logic [7:0] v, logic bo, logic [2:0] sel);
		return bo ? (o & ~(8'h01 << sel)) | (v & (8'h01 << sel)) : v;
	endfunction : upd
	task cmp(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task check_pins;
		cmp(port2_oe, ~dm[0]);
		cmp(port2_out, port2_latch & ~dm[0]);
		cmp(port3_oe, ~dm[1]);
		cmp(port3_out, port3_latch & ~dm[1]);
		cmp(port4_oe, ~dm[2]);
		cmp(port4_out, port4_latch & ~dm[2]);
		cmp(port12_oe, ~dm[3]);
		cmp(port12_out, port12_latch & ~dm[3]);
	endtask : check_pins
	task wr(input logic [15:0] a, input logic [7:0] v, input logic bo, input logic [2:0] sel);
		@(negedge core_clk);
		bus_addr = a;
		bus_wdata = v;
		bus_bit_op = bo;
		bus_bit_sel = sel;
		bus_wr = 1;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge core_clk);
		bus_wr = 0;
		bus_addr = a;
		bus_rd = 1;
		@(negedge core_clk);
		bus_rd = 0;
		cmp(bus_rdata, e);
	endtask : rd
	task end_sim;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// Generous span; normal run is near 220 cycles
	initial begin
		#10000;
		miscompares++;
		end_sim;
	end
	initial begin
		void'($urandom(32'h2143));
		{rstn, bus_wr, bus_rd, bus_bit_op, bus_bit_sel, bus_addr, bus_wdata} = '0;
		{port2_latch, port3_latch, port4_latch, port12_latch} = '0;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1;
		for (i = 0; i < 4; i++) begin
			rd(ad[i], 8'hff);
			dm[i] = 8'hff;
		end
		check_pins();
		wr(16'hff25, 8'h00, 0, 0);
		rd(16'hff25, 8'h00);
		rd(ad[0], 8'hff);
		$display("reset done");
		repeat (60) begin
			i = $urandom % 4;
			d = 8'($urandom);
			b = 1'($urandom);
			s = 3'($urandom);
			{port2_latch, port3_latch, port4_latch, port12_latch} = $urandom;
			wr(ad[i], d, b, s);
			dm[i] = upd(dm[i], d, b, s);
			rd(ad[i], dm[i]);
			check_pins();
		end
		// Quiet the shared pins so leftover pulses die out before the pulse checks
		{port3_latch, port4_latch} = 16'h0000;
		$display("random done");
		wr(PORT3_DIRECTION_ADDR, 8'hfe, 0, 0);
		rd(PORT3_DIRECTION_ADDR, 8'hfe);
		cmp(port3_oe, 8'h01);
		port3_latch = 8'h01;
		repeat (2) @(negedge core_clk);
		cmp({5'h00, intr_request_set}, 8'h01);
		@(negedge core_clk);
		cmp({5'h00, intr_request_set}, 8'h00);
		wr(PORT3_DIRECTION_ADDR, 8'h01, 1, 0);
		rd(PORT3_DIRECTION_ADDR, 8'hff);
		port3_latch = 8'h00;
		repeat (2) @(negedge core_clk);
		cmp({5'h00, intr_request_set}, 8'h00);
		wr(PORT4_DIRECTION_ADDR, 8'hf7, 0, 0);
		wr(PORT3_DIRECTION_ADDR, 8'hfd, 0, 0);
		{port3_latch, port4_latch} = {8'h02, 8'h08};
		rd(PORT3_DIRECTION_ADDR, 8'hfd);
		cmp({5'h00, intr_request_set}, 8'h06);
		dm[1] = 8'hfd;
		dm[2] = 8'hf7;
		check_pins();
		@(negedge core_clk);
		cmp({5'h00, intr_request_set}, 8'h00);
		$display("intr done");
		end_sim;
	end
endmodule : port_direction_control_test
